// file: verilog/clock_strap_latch.sv
// strap latch for host clock select and core multiplier, AXI4-Lite read port
// What this block does
// - the latch holds in bits 5..0 the levels of strap pins 26..21 in order, 7..6 reserved.
// - latch bits 5..3 from pins 26..24 drive the host clock synthesizer select.
// - select codes 000..111 pick 25, 33, 40, 50, 60, 66, 75 or 80 MHz host clock.
// - after reset the latch holds the sampled pin levels with no software write.
// - pin 40 low runs the core at one times host clock, high at two times.
// - strap pins 39..27 and 43..41 have no configuration function.
`timescale 1ns/100ps
`include "clock_strap_params.svh"
module clock_strap_latch #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // board strap levels
   input wire logic [43:0] memory_data_strap_pins,
   // clock control outputs
   output logic [2:0] synth_freq_sel,
   output logic core_mult_double,
   // axi4-lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [6:0] strap_q;
   logic [5:0] latch_bits;
   logic [7:0] latch_byte;
   clock_strap_pkg::core_mult_t core_mode;
   clock_strap_pkg::host_freq_t host_freq;

   // pins 39..27 and 43..41 are not wired anywhere: no function by design
   strap_capture #(.WIDTH(7)) u_capture (
      .aclk(aclk),
      .aresetn(aresetn),
      .strap_in({memory_data_strap_pins[`CORE_MULT_PIN],
                 memory_data_strap_pins[`STRAP_PIN_HI:`STRAP_PIN_LO]}),
      .strap_q(strap_q)
   );

   assign latch_bits = strap_q[5:0];
   assign latch_byte = {2'h0, latch_bits};
   assign host_freq = clock_strap_pkg::host_freq_t'(latch_bits[`SYNTH_SEL_HI:`SYNTH_SEL_LO]);
   assign core_mode = clock_strap_pkg::core_mult_t'(strap_q[6]);

   // registered clock controls
   logic [2:0] freq_reg, freq_next;
   logic mult_reg, mult_next;
   always_comb begin
      freq_next = host_freq;
      mult_next = (core_mode == clock_strap_pkg::double_multiplier_mode);
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         freq_reg <= 3'h0;
         mult_reg <= 1'b0;
      end else begin
         freq_reg <= freq_next;
         mult_reg <= mult_next;
      end
   end
   assign synth_freq_sel = freq_reg;
   assign core_mult_double = mult_reg;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
      addr_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
   endfunction

   // write channel: everything accepted, nothing stored
   logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic awaddr_ok_reg, awaddr_ok_next;
   logic aw_take, w_take;
   // readies are registered: a take needs the ready the master sees, not just a free slot
   logic awready_reg, wready_reg;
   always_comb begin
      aw_take = s_axi_awvalid && awready_reg;
      w_take = s_axi_wvalid && wready_reg;
      aw_have_next = aw_have_reg;
      w_have_next = w_have_reg;
      awaddr_ok_next = awaddr_ok_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      if (aw_take) begin
         aw_have_next = 1'b1;
         awaddr_ok_next = addr_hit(s_axi_awaddr, `STRAP_LATCH_OFFSET) ||
                          addr_hit(s_axi_awaddr, `CORE_MULT_OFFSET);
      end
      if (w_take) begin
         w_have_next = 1'b1;
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end else if (aw_have_reg && w_have_reg) begin
         // read-only map: a mapped write is OKAY but dropped
         bvalid_next = 1'b1;
         bresp_next = awaddr_ok_reg ? `RESP_OKAY : `RESP_SLVERR;
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_ok_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
      end else begin
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         awaddr_ok_reg <= awaddr_ok_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
      end
   end

   // ready as registered outputs: high while the slot is free and no write response is pending
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
      end else begin
         awready_reg <= !aw_have_next && !bvalid_next;
         wready_reg <= !w_have_next && !bvalid_next;
      end
   end
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // read channel
   logic rvalid_reg, rvalid_next, arready_reg, arready_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end else if (s_axi_arvalid && arready_reg) begin
         rvalid_next = 1'b1;
         rresp_next = `RESP_OKAY;
         if (addr_hit(s_axi_araddr, `STRAP_LATCH_OFFSET)) begin
            rdata_next = {24'h000000, latch_byte};
         end else if (addr_hit(s_axi_araddr, `CORE_MULT_OFFSET)) begin
            rdata_next = {31'h00000000, strap_q[6]};
         end else begin
            rdata_next = 32'h00000000;
            rresp_next = `RESP_SLVERR;
         end
      end
      arready_next = !rvalid_next;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= 2'h0;
         arready_reg <= 1'b0;
      end else begin
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         arready_reg <= arready_next;
      end
   end
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // checks
   sequence read_latch_s;
      s_axi_arvalid && s_axi_arready && addr_hit(s_axi_araddr, `STRAP_LATCH_OFFSET);
   endsequence
   sequence read_mult_s;
      s_axi_arvalid && s_axi_arready && addr_hit(s_axi_araddr, `CORE_MULT_OFFSET);
   endsequence

   latch_pin_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
      read_latch_s |=> s_axi_rvalid && s_axi_rdata[5:0] == strap_q[5:0]
      && s_axi_rdata[31:6] == 26'h0) else $error("latch read data wrong");
   synth_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> synth_freq_sel == $past(strap_q[5:3]))
      else $error("synth select not from latch bits 5..3");
   freq_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(strap_q[5:3]) == 3'h7 |-> synth_freq_sel == 3'h7)
      else $error("80 MHz code lost");
   latch_loaded_a: assert property (@(posedge aclk)
      !aresetn ##1 aresetn |-> strap_q == $past({memory_data_strap_pins[40],
      memory_data_strap_pins[26:21]}))
      else $error("latch not loaded at reset");
   core_mult_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> core_mult_double == $past(strap_q[6]))
      else $error("core multiplier not from pin 40");
   mult_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      read_mult_s |=> s_axi_rdata == {31'h0, strap_q[6]})
      else $error("multiplier read wrong");
   write_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid ##0 $stable(strap_q))
      else $error("write touched latch");
   reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("unmapped read data not zero");
endmodule

// file: verilog/clock_strap_params.svh
// constants for the clock strap latch
`ifndef CLOCK_STRAP_PARAMS_SVH
`define CLOCK_STRAP_PARAMS_SVH
`define STRAP_LATCH_OFFSET 12'h17C
`define STRAP_LATCH_INDEX 8'h5F
`define CORE_MULT_OFFSET 12'h180
`define STRAP_PIN_LO 21
`define STRAP_PIN_HI 26
`define CORE_MULT_PIN 40
`define SYNTH_SEL_LO 3
`define SYNTH_SEL_HI 5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define PIN_COUNT 44
`endif

// file: verilog/clock_strap_pkg.sv
// types for the clock strap latch
package clock_strap_pkg;
   typedef enum logic [2:0] {
      freq_25, freq_33, freq_40, freq_50, freq_60, freq_66, freq_75, freq_80
   } host_freq_t;
   typedef enum logic {unity_multiplier_mode, double_multiplier_mode} core_mult_t;
endpackage

// file: verilog/strap_capture.sv
// captures strap levels while system reset is held, frozen after release
`timescale 1ns/100ps
module strap_capture #(
   parameter int WIDTH = 7
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // levels in, held value out
   input wire logic [WIDTH-1:0] strap_in,
   output logic [WIDTH-1:0] strap_q
);
   logic [WIDTH-1:0] strap_reg;
   logic [WIDTH-1:0] strap_next;

   // a sync reset lets us sample pins during reset without loading a port async
   always_comb begin
      strap_next = strap_reg;
      if (!aresetn) begin
         strap_next = strap_in;
      end
   end

   always_ff @(posedge aclk) begin
      strap_reg <= strap_next;
   end

   assign strap_q = strap_reg;

   frozen_after_a: assert property (@(posedge aclk) aresetn && $past(aresetn)
      |-> $stable(strap_reg)) else $error("strap latch moved after reset");
endmodule

// file: tb/strap_board.sv
// board strap resistors: fixed pulls on reserved pins, jumpers on the used ones
`timescale 1ns/100ps
module strap_board (
   // jumper fitting
   input wire logic [2:0] freq_jumper,
   input wire logic mult_jumper,
   // deliberate misfits on reserved pins
   input wire logic [43:0] miswire,
   // strap levels
   output logic [43:0] memory_data_strap_pins
);
   localparam logic [43:0] PULLS = 44'h4F000FFFFFF;
   always_comb begin
      memory_data_strap_pins = PULLS ^ miswire;
      memory_data_strap_pins[26:24] = freq_jumper;
      // resistor to ground unless the jumper fits the pull-up
      memory_data_strap_pins[40] = mult_jumper;
   end
endmodule

// file: tb/clock_strap_latch_bench.sv
// self-checking bench: strap capture, clock select outputs and register port
`timescale 1ns/100ps
`include "clock_strap_params.svh"
module clock_strap_latch_bench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [2:0] freq_jumper = 3'h0;
   logic mult_jumper = 1'b0;
   logic [43:0] miswire = 44'h0;
   logic [43:0] pins;
   logic [2:0] synth_freq_sel;
   logic core_mult_double;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   integer seed = 32'h69AD8779;
   int fails = 0;
   int comparisons = 0;
   always #25 aclk = ~aclk;
   strap_board board (.freq_jumper(freq_jumper), .mult_jumper(mult_jumper),
      .miswire(miswire), .memory_data_strap_pins(pins));
   clock_strap_latch uut (.aclk(aclk), .aresetn(aresetn), .memory_data_strap_pins(pins),
      .synth_freq_sel(synth_freq_sel), .core_mult_double(core_mult_double),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   function automatic logic [31:0] latch_word(input logic [43:0] p);
      return {26'h0, p[26:21]};
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic summarize;
      $display("comparisons %0d, fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // no wait limit of its own: only the watchdog ends a hung transfer
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic wr(input logic [11:0] a, output logic [1:0] r);
      awaddr <= a;
      wdata <= $random(seed);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   // generous: each test takes about twenty cycles
   initial begin
      repeat (3000) @(posedge aclk);
      fails++;
      summarize();
   end
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [43:0] snap;
      // first sixteen walk every select code with both multipliers, the rest random
      for (int t = 0; t < 20; t++) begin
         @(posedge aclk);
         {mult_jumper, freq_jumper} <= (t < 16) ? t[3:0] : 4'($random(seed));
         miswire <= 44'({$random(seed), $random(seed)});
         aresetn <= 1'b0;
         repeat (4) @(posedge aclk);
         aresetn <= 1'b1;
         snap = pins;
         repeat (2) @(posedge aclk);
         chk("freq select", {29'h0, snap[26:24]}, {29'h0, synth_freq_sel});
         chk("core multiplier", {31'h0, snap[40]}, {31'h0, core_mult_double});
         rd(`STRAP_LATCH_OFFSET, d, r);
         chk("latch read", latch_word(snap), d);
         chk("latch resp", {30'h0, `RESP_OKAY}, {30'h0, r});
         rd(`CORE_MULT_OFFSET, d, r);
         chk("multiplier read", {31'h0, snap[40]}, d);
         // straps moving after release must not reach the latch
         {mult_jumper, freq_jumper} <= ~{snap[40], snap[26:24]};
         miswire <= ~miswire;
         wr(`STRAP_LATCH_OFFSET, r);
         chk("write resp", {30'h0, `RESP_OKAY}, {30'h0, r});
         rd(`STRAP_LATCH_OFFSET, d, r);
         chk("latch frozen", latch_word(snap), d);
         chk("freq frozen", {29'h0, snap[26:24]}, {29'h0, synth_freq_sel});
         chk("mult frozen", {31'h0, snap[40]}, {31'h0, core_mult_double});
         $display("test %0d done", t);
      end
      rd(12'h004, d, r);
      chk("unmapped data", 32'h0, d);
      chk("unmapped resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
      wr(12'h7F0, r);
      chk("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, r});
      $display("test unmapped done");
      summarize();
   end
endmodule
